//--- hdl/msi_pkg.sv
// shared constants, types and register layout for the midi setup interpreter
`default_nettype none
package msi_pkg;
  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_SYSTEM = 8'h00;
  localparam logic [7:0] REG_MIDI1 = 8'h04;
  localparam logic [7:0] REG_MIDI2 = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_BULK_CNT = 8'h10;
  // system register fields
  localparam int SYS_TRANSPOSE_LSB = 0;
  localparam int SYS_TUNE_LSB = 8;
  localparam int SYS_CTRL_RESET_BIT = 16;
  localparam int SYS_LOCAL_BIT = 17;
  // midi1 register fields
  localparam int M1_TX_LSB = 0;
  localparam int M1_RX_LSB = 4;
  localparam int M1_OMNI_BIT = 8;
  localparam int M1_DEV_LSB = 12;
  localparam int M1_DEVMODE_LSB = 16;
  // midi2 register fields
  localparam int M2_VOL_LSB = 0;
  localparam int M2_PCHG_LSB = 8;
  localparam int M2_PROT_BIT = 12;
  // status register fields
  localparam int ST_MODE_LSB = 0;
  localparam int ST_CARD_BIT = 2;
  localparam int ST_BANK_LSB = 3;
  localparam int ST_PROG_LSB = 8;
  localparam int ST_VOL_LSB = 16;
  // value limits and fixed numbers of the protocol
  localparam logic [6:0] OFFSET_MAX = 7'h3F;
  localparam logic [6:0] OFFSET_MIN = 7'h41;
  localparam logic [6:0] OFFSET_BAD = 7'h40;
  localparam logic [6:0] VOL_CTRL_MAX = 7'h79;
  localparam logic [6:0] PROG_NORM_MAX = 7'h3F;
  localparam logic [6:0] BANK_CC_MSB = 7'h00;
  localparam logic [6:0] BANK_CC_LSB = 7'h20;
  localparam logic [6:0] BANK_MSB_DIRECT = 7'h00;
  localparam logic [6:0] NOTE_MAX = 7'h7F;
  localparam logic signed [14:0] CENTS_X100_PER_STEP = 15'sh0075;
  // reset values
  localparam logic [6:0] VOL_CTRL_RST = 7'h07;
  localparam logic [6:0] VOLUME_RST = 7'h7F;
  localparam logic [3:0] CHAN_RST = 4'h0;

  typedef enum logic [2:0] {KIND_NOTE_OFF, KIND_NOTE_ON, KIND_CTRL, KIND_PROG, KIND_OTHER}
    msi_kind_e;
  typedef enum logic [1:0] {PCHG_OFF, PCHG_NORM, PCHG_DIRECT, PCHG_TABLE} msi_pchg_mode_e;
  typedef enum logic [1:0] {DEV_OFF, DEV_NUM, DEV_ALL} msi_dev_mode_e;
  typedef enum logic [1:0] {OP_VOICE, OP_PERF, OP_MULTI_VOICE, OP_MULTI_PERF} msi_opmode_e;

  // one channel message; chan 0 stands for midi channel 1
  typedef struct packed {
    msi_kind_e kind;
    logic [3:0] chan;
    logic [6:0] d1;
    logic [6:0] d2;
  } msi_msg_s;

  // current voice or performance selection
  typedef struct packed {
    msi_opmode_e mode;
    logic card;
    logic [1:0] bank;
    logic [5:0] prog;
  } msi_sel_s;
endpackage
`default_nettype wire

//--- hdl/msi_interp.sv
// midi setup interpreter: setup registers, message routing, program and bank decoding
//
// The register addresses and strobed register access were decided locally.
`default_nettype none
module msi_interp
  import msi_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [ADDR_W-1:0] i_reg_addr,
  input wire logic [DATA_W-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [DATA_W-1:0] o_reg_rdata,
  input wire logic i_kbd_valid,
  input wire msi_msg_s i_kbd_msg,
  input wire logic i_rx_valid,
  input wire msi_msg_s i_rx_msg,
  input wire logic i_panel_valid,
  input wire msi_sel_s i_panel_sel,
  input wire logic [6:0] i_panel_tbl_prog,
  input wire logic i_sx_valid,
  input wire logic [3:0] i_sx_dev,
  input wire logic i_sx_bulk,
  output logic o_tg_kbd_valid,
  output msi_msg_s o_tg_kbd_msg,
  output logic o_tg_rx_valid,
  output msi_msg_s o_tg_rx_msg,
  output logic o_tx_valid,
  output msi_msg_s o_tx_msg,
  output logic o_sel_valid,
  output msi_sel_s o_sel,
  output logic o_ctrl_reset,
  output logic [6:0] o_volume,
  output logic signed [14:0] o_fine_cents_x100,
  output logic o_sx_accept,
  output logic o_bulk_accept,
  output logic o_bulk_reject,
  output logic o_sx_tx_enable,
  output logic [3:0] o_sx_tx_dev
);

  // setup state
  logic [6:0] transpose;
  logic [6:0] tune;
  logic ctrl_reset_on_change;
  logic local_on;
  logic [3:0] tx_chan;
  logic [3:0] rx_chan;
  logic omni;
  logic [3:0] sysex_device_number;
  msi_dev_mode_e dev_mode;
  logic [6:0] volume_controller_number;
  msi_pchg_mode_e program_change_mode;
  logic bulk_prot;
  logic [6:0] bank_msb;
  logic pend_valid;
  logic [6:0] pend_prog;
  logic [CNT_W-1:0] bulk_rej_cnt;

  // clamp a written offset: the code for -64 is outside the range and becomes -63
  function automatic logic [6:0] clamp_offset(input logic [6:0] v);
    clamp_offset = (v == OFFSET_BAD) ? OFFSET_MIN : v;
  endfunction

  // add the signed shift and pin the result inside the note range
  function automatic logic [6:0] shift_note(input logic [6:0] n, input logic [6:0] s);
    logic signed [8:0] sum;
    sum = $signed({2'b00, n}) + $signed({{2{s[6]}}, s});
    if (sum < 0) begin
      shift_note = 7'h00;
    end else if (sum > $signed({2'b00, NOTE_MAX})) begin
      shift_note = NOTE_MAX;
    end else begin
      shift_note = sum[6:0];
    end
  endfunction

  // transpose only note messages, everything else passes through
  function automatic msi_msg_s apply_shift(input msi_msg_s m, input logic [6:0] s);
    apply_shift = m;
    if (m.kind == KIND_NOTE_ON || m.kind == KIND_NOTE_OFF) begin
      apply_shift.d1 = shift_note(m.d1, s);
    end
  endfunction

  // bank lsb to mode and memory; bit 5 of the result says the code is listed
  function automatic logic [5:0] bank_decode(input logic [6:0] lsb);
    logic ok;
    logic card;
    logic [1:0] bank;
    logic [1:0] mode;
    ok = 1'b0;
    card = 1'b0;
    bank = 2'b00;
    mode = OP_VOICE;
    unique case (lsb[6:4])
      3'h0, 3'h2: begin
        mode = (lsb[6:4] == 3'h2) ? OP_MULTI_VOICE : OP_VOICE;
        unique case (lsb[3:0])
          4'h0: begin ok = 1'b1; bank = 2'h0; end
          4'h3: begin ok = 1'b1; bank = 2'h1; end
          4'h6: begin ok = 1'b1; bank = 2'h2; end
          4'h9: begin ok = 1'b1; bank = 2'h3; end
          4'h1: begin ok = 1'b1; card = 1'b1; bank = 2'h0; end
          4'h4: begin ok = 1'b1; card = 1'b1; bank = 2'h1; end
          4'h7: begin ok = 1'b1; card = 1'b1; bank = 2'h2; end
          4'hA: begin ok = 1'b1; card = 1'b1; bank = 2'h3; end
          default: ok = 1'b0;
        endcase
      end
      3'h4, 3'h5: begin
        mode = (lsb[6:4] == 3'h5) ? OP_MULTI_PERF : OP_PERF;
        unique case (lsb[3:0])
          4'h0: begin ok = 1'b1; bank = 2'h0; end
          4'h3: begin ok = 1'b1; bank = 2'h1; end
          4'h1: begin ok = 1'b1; card = 1'b1; bank = 2'h0; end
          4'h4: begin ok = 1'b1; card = 1'b1; bank = 2'h1; end
          default: ok = 1'b0;
        endcase
      end
      default: ok = 1'b0;
    endcase
    bank_decode = {ok, mode, card, bank};
  endfunction

  // register write decode
  wire wr_sys = i_reg_wr && (i_reg_addr == REG_SYSTEM);
  wire wr_m1 = i_reg_wr && (i_reg_addr == REG_MIDI1);
  wire wr_m2 = i_reg_wr && (i_reg_addr == REG_MIDI2);
  wire [6:0] wr_vol = i_reg_wdata[M2_VOL_LSB +: 7];
  wire [1:0] wr_devmode = i_reg_wdata[M1_DEVMODE_LSB +: 2];

  // receive filtering; a bank or program code outside the tables is dropped
  wire rx_chan_ok = omni || (i_rx_msg.chan == rx_chan);
  wire rx_take = i_rx_valid && rx_chan_ok;
  wire rx_ctrl = rx_take && (i_rx_msg.kind == KIND_CTRL);
  wire rx_vol = rx_ctrl && (i_rx_msg.d1 == volume_controller_number);
  wire rx_bank_msb = rx_ctrl && (i_rx_msg.d1 == BANK_CC_MSB);
  wire bank_sel_on = (program_change_mode == PCHG_DIRECT)
    || (program_change_mode == PCHG_TABLE);
  wire [5:0] bank_dec = bank_decode(i_rx_msg.d2);
  wire rx_bank_lsb = rx_ctrl && (i_rx_msg.d1 == BANK_CC_LSB) && bank_sel_on
    && (bank_msb == BANK_MSB_DIRECT) && bank_dec[5];
  wire rx_prog = rx_take && (i_rx_msg.kind == KIND_PROG)
    && (program_change_mode != PCHG_OFF) && (i_rx_msg.d1 <= PROG_NORM_MAX);

  // next selection: panel first, then received bank and program within one cycle
  msi_sel_s next_sel;
  always_comb begin
    next_sel = o_sel;
    if (i_panel_valid) begin
      next_sel = i_panel_sel;
    end
    if (rx_bank_lsb) begin
      next_sel.mode = msi_opmode_e'(bank_dec[4:3]);
      next_sel.card = bank_dec[2];
      next_sel.bank = bank_dec[1:0];
    end
    if (rx_prog) begin
      next_sel.prog = i_rx_msg.d1[5:0];
    end
  end
  wire sel_event = i_panel_valid || rx_bank_lsb || rx_prog;

  // outgoing program change: table value in table mode, else the panel number
  wire [6:0] panel_prog = (program_change_mode == PCHG_TABLE) ? i_panel_tbl_prog
    : {1'b0, i_panel_sel.prog};
  // keyboard owns the output slot; a program change waits in a single holder until a slot without a keyboard message
  wire tx_prog_go = !i_kbd_valid && (pend_valid || i_panel_valid);
  // a fresh panel change beats a waiting one, so the newest program always goes out
  wire [6:0] tx_prog_val = i_panel_valid ? panel_prog : pend_prog;
  msi_msg_s next_tx;
  always_comb begin
    next_tx = o_tx_msg;
    if (i_kbd_valid) begin
      next_tx = apply_shift(i_kbd_msg, transpose);
      next_tx.chan = tx_chan;
    end else if (tx_prog_go) begin
      next_tx.kind = KIND_PROG;
      next_tx.chan = tx_chan;
      next_tx.d1 = tx_prog_val;
      next_tx.d2 = 7'h00;
    end
  end

  // sysex device match
  wire sx_match = (dev_mode == DEV_ALL)
    || ((dev_mode == DEV_NUM) && (i_sx_dev == sysex_device_number));

  // register read mux, unmapped addresses read zero
  wire [DATA_W-1:0] rd_sys = {14'h0000, local_on, ctrl_reset_on_change, 1'b0, tune,
    1'b0, transpose};
  wire [DATA_W-1:0] rd_m1 = {14'h0000, dev_mode, sysex_device_number, 3'h0, omni,
    rx_chan, tx_chan};
  wire [DATA_W-1:0] rd_m2 = {19'h00000, bulk_prot, 2'h0, program_change_mode, 1'b0,
    volume_controller_number};
  wire [DATA_W-1:0] rd_st = {9'h000, o_volume, 2'h0, o_sel.prog, 3'h0, o_sel.bank,
    o_sel.card, o_sel.mode};
  wire [DATA_W-1:0] rd_cnt = DATA_W'(bulk_rej_cnt);
  wire [DATA_W-1:0] rd_mux = (i_reg_addr == REG_SYSTEM) ? rd_sys
    : (i_reg_addr == REG_MIDI1) ? rd_m1
    : (i_reg_addr == REG_MIDI2) ? rd_m2
    : (i_reg_addr == REG_STATUS) ? rd_st
    : (i_reg_addr == REG_BULK_CNT) ? rd_cnt : '0;

  // setup registers written by software
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      transpose <= 7'h00;
      tune <= 7'h00;
      ctrl_reset_on_change <= 1'b0;
      local_on <= 1'b1;
      tx_chan <= CHAN_RST;
      rx_chan <= CHAN_RST;
      omni <= 1'b0;
      sysex_device_number <= CHAN_RST;
      dev_mode <= DEV_NUM;
      volume_controller_number <= VOL_CTRL_RST;
      program_change_mode <= PCHG_NORM;
      bulk_prot <= 1'b0;
    end else begin
      if (wr_sys) begin
        transpose <= clamp_offset(i_reg_wdata[SYS_TRANSPOSE_LSB +: 7]);
        tune <= clamp_offset(i_reg_wdata[SYS_TUNE_LSB +: 7]);
        ctrl_reset_on_change <= i_reg_wdata[SYS_CTRL_RESET_BIT];
        local_on <= i_reg_wdata[SYS_LOCAL_BIT];
      end
      if (wr_m1) begin
        tx_chan <= i_reg_wdata[M1_TX_LSB +: 4];
        rx_chan <= i_reg_wdata[M1_RX_LSB +: 4];
        omni <= i_reg_wdata[M1_OMNI_BIT];
        sysex_device_number <= i_reg_wdata[M1_DEV_LSB +: 4];
        dev_mode <= (wr_devmode > 2'(DEV_ALL)) ? DEV_OFF : msi_dev_mode_e'(wr_devmode);
      end
      if (wr_m2) begin
        volume_controller_number <= (wr_vol > VOL_CTRL_MAX) ? VOL_CTRL_MAX : wr_vol;
        program_change_mode <= msi_pchg_mode_e'(i_reg_wdata[M2_PCHG_LSB +: 2]);
        bulk_prot <= i_reg_wdata[M2_PROT_BIT];
      end
    end
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= '0;
    end else begin
      o_reg_rdata <= i_reg_rd ? rd_mux : '0;
    end
  end

  // received message handling: tone generator, volume, bank and selection
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_tg_rx_valid <= 1'b0;
      o_tg_rx_msg <= '0;
      o_volume <= VOLUME_RST;
      bank_msb <= BANK_MSB_DIRECT;
      o_sel <= '0;
      o_sel_valid <= 1'b0;
      o_ctrl_reset <= 1'b0;
    end else begin
      o_tg_rx_valid <= rx_take;
      o_tg_rx_msg <= rx_take ? apply_shift(i_rx_msg, transpose) : o_tg_rx_msg;
      if (rx_vol) begin
        o_volume <= i_rx_msg.d2;
      end
      if (rx_bank_msb) begin
        bank_msb <= i_rx_msg.d2;
      end
      o_sel <= next_sel;
      o_sel_valid <= sel_event;
      o_ctrl_reset <= sel_event && ctrl_reset_on_change;
    end
  end

  // keyboard path: tone generator only with local on, midi out always
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_tg_kbd_valid <= 1'b0;
      o_tg_kbd_msg <= '0;
      o_tx_valid <= 1'b0;
      o_tx_msg <= '0;
      pend_valid <= 1'b0;
      pend_prog <= 7'h00;
    end else begin
      o_tg_kbd_valid <= i_kbd_valid && local_on;
      o_tg_kbd_msg <= i_kbd_valid ? apply_shift(i_kbd_msg, transpose) : o_tg_kbd_msg;
      o_tx_valid <= i_kbd_valid || tx_prog_go;
      o_tx_msg <= next_tx;
      // a new panel change while one waits replaces it: only the latest matters
      pend_valid <= i_kbd_valid && (pend_valid || i_panel_valid);
      pend_prog <= i_panel_valid ? panel_prog : pend_prog;
    end
  end

  // sysex acceptance, bulk protection and fine tune output
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sx_accept <= 1'b0;
      o_bulk_accept <= 1'b0;
      o_bulk_reject <= 1'b0;
      bulk_rej_cnt <= '0;
      o_sx_tx_enable <= 1'b0;
      o_sx_tx_dev <= CHAN_RST;
      o_fine_cents_x100 <= '0;
    end else begin
      o_sx_accept <= i_sx_valid && sx_match && !i_sx_bulk;
      o_bulk_accept <= i_sx_valid && sx_match && i_sx_bulk && !bulk_prot;
      o_bulk_reject <= i_sx_valid && i_sx_bulk && bulk_prot;
      if (i_sx_valid && i_sx_bulk && bulk_prot) begin
        bulk_rej_cnt <= bulk_rej_cnt + CNT_W'(1);
      end
      o_sx_tx_enable <= (dev_mode != DEV_OFF);
      o_sx_tx_dev <= sysex_device_number;
      o_fine_cents_x100 <= $signed({{8{tune[6]}}, tune}) * CENTS_X100_PER_STEP;
    end
  end

  // checks on the design's own outputs
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  a_local_off_mute: assert property (
    i_kbd_valid && !local_on |=> !o_tg_kbd_valid && o_tx_valid)
    else $error("keyboard note reached tone generator with local off");
  a_rx_always_plays: assert property (
    i_rx_valid && (omni || i_rx_msg.chan == rx_chan) |=> o_tg_rx_valid)
    else $error("accepted midi input not played");
  a_tx_channel: assert property (
    o_tx_valid |-> o_tx_msg.chan == $past(tx_chan))
    else $error("message sent on wrong channel");
  a_rx_chan_filter: assert property (
    i_rx_valid && !omni && i_rx_msg.chan != rx_chan |=> !o_tg_rx_valid)
    else $error("message on foreign channel accepted");
  a_sysex_off_ignore: assert property (
    i_sx_valid && dev_mode == DEV_OFF |=> !o_sx_accept && !o_bulk_accept)
    else $error("sysex accepted with device number off");
  a_volume_cc: assert property (
    rx_ctrl && i_rx_msg.d1 == volume_controller_number |=> o_volume == $past(i_rx_msg.d2))
    else $error("volume controller not applied");
  a_pchg_off: assert property (
    program_change_mode == PCHG_OFF && !i_panel_valid |=> $stable(o_sel.prog))
    else $error("program change acted on in mode off");
  a_norm_no_bank: assert property (
    program_change_mode == PCHG_NORM && !i_panel_valid |=> $stable(o_sel.mode))
    else $error("bank select changed mode in normal mode");
  a_ctrl_reset: assert property (
    o_sel_valid |-> o_ctrl_reset == $past(ctrl_reset_on_change))
    else $error("controller reset pulse does not follow setting");
  a_bulk_protect: assert property (
    i_sx_valid && i_sx_bulk && bulk_prot |=> o_bulk_reject && !o_bulk_accept)
    else $error("bulk dump accepted under protection");
  a_bulk_open: assert property (
    i_sx_valid && i_sx_bulk && !bulk_prot && sx_match |=> o_bulk_accept)
    else $error("matching bulk dump not accepted");
  a_pend_drains: assert property (
    pend_valid && !i_kbd_valid |=> o_tx_valid && o_tx_msg.kind == KIND_PROG)
    else $error("waiting program change not sent");

  c_bank_switch: cover property (rx_bank_lsb ##1 o_sel_valid);
  c_bulk_reject: cover property (o_bulk_reject);
  c_local_off_play: cover property (i_kbd_valid && !local_on);
  c_omni_rx: cover property (i_rx_valid && omni && i_rx_msg.chan != rx_chan);

endmodule
`default_nettype wire

//--- bench/msi_midi_peer.sv
// external midi gear: sends parsed channel messages and sysex headers
`default_nettype none
module msi_midi_peer
  import msi_pkg::*;
(
  input wire logic i_clk_sys,
  output logic o_rx_valid,
  output msi_msg_s o_rx_msg,
  output logic o_sx_valid,
  output logic [3:0] o_sx_dev,
  output logic o_sx_bulk
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle at time zero
  initial begin
    o_rx_valid = 1'b0;
    o_rx_msg = '0;
    o_sx_valid = 1'b0;
    o_sx_dev = 4'h0;
    o_sx_bulk = 1'b0;
  end

  // one message per call; released lines are inverted so stale data never looks valid
  task automatic send_chan(input msi_kind_e k, input logic [3:0] ch, input logic [6:0] a,
                           input logic [6:0] b);
    @(posedge i_clk_sys);
    o_rx_valid <= 1'b1;
    o_rx_msg <= '{kind: k, chan: ch, d1: a, d2: b};
    @(posedge i_clk_sys);
    o_rx_valid <= 1'b0;
    o_rx_msg <= msi_msg_s'(~o_rx_msg);
    #1;
  endtask

  // sysex header carrying a device number, optionally a bulk dump
  task automatic send_sx(input logic [3:0] dev, input logic bulk);
    @(posedge i_clk_sys);
    o_sx_valid <= 1'b1;
    o_sx_dev <= dev;
    o_sx_bulk <= bulk;
    @(posedge i_clk_sys);
    o_sx_valid <= 1'b0;
    o_sx_dev <= ~dev;
    o_sx_bulk <= ~bulk;
    #1;
  endtask
endmodule
`default_nettype wire

//--- bench/msi_interp_test.sv
// self-checking bench for the midi setup interpreter
`default_nettype none
module msi_interp_test
  import msi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); end end

  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic kv = 1'b0;
  msi_msg_s km = '0;
  logic pv = 1'b0;
  msi_sel_s ps = '0;
  logic [6:0] tbl = 7'h00;
  logic [31:0] rdata;
  logic rxv, sxv, sxb, tgk_v, tgr_v, tx_v, sel_v, crst, sxa, bla, blr, sxe;
  msi_msg_s rxm, tgk_m, tgr_m, tx_m;
  msi_sel_s sel;
  logic [3:0] sxdev, sxd;
  logic [6:0] vol;
  logic signed [14:0] cents;
  logic [6:0] code;
  logic [6:0] base [4] = '{7'h00, 7'h40, 7'h20, 7'h50};
  int fail_count = 0;
  int num_checks = 0;

  msi_midi_peer u_peer (.i_clk_sys(clk), .o_rx_valid(rxv), .o_rx_msg(rxm), .o_sx_valid(sxv),
    .o_sx_dev(sxdev), .o_sx_bulk(sxb));

  msi_interp u_dut (.i_clk_sys(clk), .i_resetn(resetn), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr_s), .i_reg_rd(rd_s), .o_reg_rdata(rdata),
    .i_kbd_valid(kv), .i_kbd_msg(km), .i_rx_valid(rxv), .i_rx_msg(rxm),
    .i_panel_valid(pv), .i_panel_sel(ps), .i_panel_tbl_prog(tbl), .i_sx_valid(sxv),
    .i_sx_dev(sxdev), .i_sx_bulk(sxb), .o_tg_kbd_valid(tgk_v), .o_tg_kbd_msg(tgk_m),
    .o_tg_rx_valid(tgr_v), .o_tg_rx_msg(tgr_m), .o_tx_valid(tx_v), .o_tx_msg(tx_m),
    .o_sel_valid(sel_v), .o_sel(sel), .o_ctrl_reset(crst), .o_volume(vol),
    .o_fine_cents_x100(cents), .o_sx_accept(sxa), .o_bulk_accept(bla),
    .o_bulk_reject(blr), .o_sx_tx_enable(sxe), .o_sx_tx_dev(sxd));

  // 100 MHz system clock
  initial begin
    forever #5 clk = ~clk;
  end

  // register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  // register read; data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask

  // keyboard note; the block puts the transmit channel on midi out, the tone generator gets the channel field as sent
  task automatic key(input logic [6:0] n);
    @(posedge clk);
    kv <= 1'b1;
    km <= '{kind: KIND_NOTE_ON, chan: 4'hF, d1: n, d2: 7'h40};
    @(posedge clk);
    kv <= 1'b0;
    #1;
  endtask

  // panel voice selection with its table program number
  task automatic pan(input logic [5:0] p, input logic [6:0] t);
    @(posedge clk);
    pv <= 1'b1;
    ps <= '{mode: OP_VOICE, card: 1'b0, bank: 2'h0, prog: p};
    tbl <= t;
    @(posedge clk);
    pv <= 1'b0;
    #1;
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end

  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(REG_SYSTEM, 32'h00020000);
    rd_chk(REG_MIDI1, 32'h00010000);
    rd_chk(REG_MIDI2, 32'h00000107);
    rd_chk(8'h14, 32'h0);
    `CHK(vol, 7'h7F)
    `CHK(cents, 15'sh0000)
    // transpose: 0x40 is stored as -63, low notes clamp at zero
    wr(REG_SYSTEM, 32'h00020040);
    rd_chk(REG_SYSTEM, 32'h00020041);
    key(7'h0A);
    `CHK(tx_m.d1, 7'h00)
    wr(REG_SYSTEM, 32'h00023F05);
    key(7'h3C);
    `CHK(tx_m.d1, 7'h41)
    `CHK(tgk_m.d1, 7'h41)
    `CHK(tgk_v, 1'b1)
    `CHK(cents, 15'sh1CCB)
    wr(REG_SYSTEM, 32'h00004100);
    // the fine tune output follows the stored setting one edge later
    @(posedge clk);
    #1;
    `CHK(cents, -15'sh1CCB)
    // local off, transmit on channel 9, receive on channel 4
    wr(REG_MIDI1, 32'h00010038);
    key(7'h3C);
    `CHK(tx_v, 1'b1)
    `CHK(tx_m.chan, 4'h8)
    `CHK(tgk_v, 1'b0)
    u_peer.send_chan(KIND_NOTE_ON, 4'h3, 7'h3C, 7'h40);
    `CHK(tgr_v, 1'b1)
    `CHK(tgr_m.d1, 7'h3C)
    u_peer.send_chan(KIND_NOTE_ON, 4'h4, 7'h3C, 7'h40);
    `CHK(tgr_v, 1'b0)
    wr(REG_MIDI1, 32'h00010138);
    u_peer.send_chan(KIND_NOTE_ON, 4'h4, 7'h3C, 7'h40);
    `CHK(tgr_v, 1'b1)
    // volume follows only the chosen controller; large numbers clamp to 121
    wr(REG_MIDI2, 32'h0000010A);
    u_peer.send_chan(KIND_CTRL, 4'h3, 7'h0A, 7'h33);
    u_peer.send_chan(KIND_CTRL, 4'h3, 7'h07, 7'h11);
    `CHK(vol, 7'h33)
    wr(REG_MIDI2, 32'h0000017F);
    rd_chk(REG_MIDI2, 32'h00000179);
    // program change modes off and normal, with and without controller reset
    wr(REG_MIDI2, 32'h00000007);
    u_peer.send_chan(KIND_PROG, 4'h3, 7'h05, 7'h00);
    `CHK(sel_v, 1'b0)
    wr(REG_MIDI2, 32'h00000107);
    wr(REG_SYSTEM, 32'h00010000);
    u_peer.send_chan(KIND_PROG, 4'h3, 7'h05, 7'h00);
    `CHK(sel_v, 1'b1)
    `CHK(sel.prog, 6'h05)
    `CHK(crst, 1'b1)
    u_peer.send_chan(KIND_PROG, 4'h3, 7'h40, 7'h00);
    `CHK(sel_v, 1'b0)
    wr(REG_SYSTEM, 32'h00000000);
    u_peer.send_chan(KIND_PROG, 4'h3, 7'h06, 7'h00);
    `CHK(crst, 1'b0)
    // direct mode: every listed bank code after a zero bank msb
    wr(REG_MIDI2, 32'h00000207);
    u_peer.send_chan(KIND_CTRL, 4'h3, BANK_CC_MSB, 7'h00);
    for (int m = 0; m < 4; m++) begin
      for (int b = 0; b < ((m % 2) ? 2 : 4); b++) begin
        for (int c = 0; c < 2; c++) begin
          code = base[m] + 7'(b * 3 + c);
          u_peer.send_chan(KIND_CTRL, 4'h3, BANK_CC_LSB, code);
          `CHK(sel_v, 1'b1)
          `CHK(sel.mode, msi_opmode_e'(m))
          `CHK(sel.card, c[0])
          `CHK(sel.bank, b[1:0])
          `CHK(sel.prog, 6'h06)
        end
      end
    end
    u_peer.send_chan(KIND_CTRL, 4'h3, BANK_CC_LSB, 7'h02);
    `CHK(sel_v, 1'b0)
    u_peer.send_chan(KIND_PROG, 4'h3, 7'h09, 7'h00);
    `CHK(sel.prog, 6'h09)
    u_peer.send_chan(KIND_CTRL, 4'h3, BANK_CC_MSB, 7'h01);
    u_peer.send_chan(KIND_CTRL, 4'h3, BANK_CC_LSB, 7'h03);
    `CHK(sel_v, 1'b0)
    // table mode receives like direct and sends the table value
    wr(REG_MIDI2, 32'h00000307);
    u_peer.send_chan(KIND_CTRL, 4'h3, BANK_CC_MSB, 7'h00);
    u_peer.send_chan(KIND_CTRL, 4'h3, BANK_CC_LSB, 7'h43);
    `CHK(sel.mode, OP_PERF)
    pan(6'h0C, 7'h55);
    `CHK(tx_m.kind, KIND_PROG)
    `CHK(tx_m.d1, 7'h55)
    wr(REG_MIDI2, 32'h00000107);
    pan(6'h0C, 7'h55);
    `CHK(tx_m.d1, 7'h0C)
    // keyboard and panel in one cycle: the note goes first, the program change waits a slot
    fork
      key(7'h3C);
      pan(6'h0D, 7'h55);
    join
    `CHK(tx_m.kind, KIND_NOTE_ON)
    @(posedge clk);
    #1;
    `CHK(tx_m.kind, KIND_PROG)
    `CHK(tx_m.chan, 4'h8)
    `CHK(tx_m.d1, 7'h0D)
    // sysex device number 5, off, all; then bulk with and without protection
    wr(REG_MIDI1, 32'h00014138);
    u_peer.send_sx(4'h4, 1'b0);
    `CHK(sxa, 1'b1)
    `CHK(sxd, 4'h4)
    `CHK(sxe, 1'b1)
    u_peer.send_sx(4'h5, 1'b0);
    `CHK(sxa, 1'b0)
    wr(REG_MIDI1, 32'h00004138);
    u_peer.send_sx(4'h4, 1'b0);
    `CHK(sxa, 1'b0)
    `CHK(sxe, 1'b0)
    wr(REG_MIDI1, 32'h00024138);
    u_peer.send_sx(4'h9, 1'b0);
    `CHK(sxa, 1'b1)
    wr(REG_MIDI1, 32'h00014138);
    u_peer.send_sx(4'h4, 1'b1);
    `CHK(bla, 1'b1)
    u_peer.send_sx(4'h5, 1'b1);
    `CHK(bla, 1'b0)
    wr(REG_MIDI2, 32'h00001107);
    u_peer.send_sx(4'h4, 1'b1);
    `CHK(blr, 1'b1)
    `CHK(bla, 1'b0)
    rd_chk(REG_BULK_CNT, 32'h1);
    report_and_stop();
  end
endmodule
`default_nettype wire
